// ---- pkg/scm_pkg.sv ----
// scm_pkg: constants, formats and carriers of the capacitance and
// temperature correction datapath.
// assumes samples are unsigned and coefficients are held steady by the coefficient store.
package scm_pkg;
   localparam int RAW_W = 14;
   localparam int COEF_W = 16;
   localparam int OUT_W = 16;
   localparam logic [1:0] RES_DEFAULT = 2'h3;
   // midscale of the 14-bit input, pivot of the offset
   localparam int MID_SCALE = 32'h0000_2000;
   // fixed-point scalings of the coefficient slots
   localparam int DRIFT_SQ_SH = 8;
   localparam int DRIFT_SH = 12;
   localparam int DEN_SH = 16;
   localparam int GAIN_SH = 12;
   localparam int SQ_SH = 30;
   localparam int CUBE_SH = 46;
   localparam int TSQ_SH = 28;
   localparam int TG_SH = 14;
   // divider: dividend bits, one quotient bit per cycle
   localparam int DIV_W = 48;
   localparam logic [5:0] DIV_LAST = 6'h2f;
   localparam int CAP_MAX = 32'h0000_ffff;
   localparam int TEMP_MAX = 32'h0000_7fff;
   localparam int TEMP_MIN = -32'sh0000_8000;

   typedef enum logic {MODE_TWO_REGION, MODE_THIRD_ORDER} mode_t;

   typedef struct packed {
      logic [RAW_W-1:0] cap;
      logic [RAW_W-1:0] temp;
   } sample_t;

   typedef struct packed {
      logic signed [COEF_W-1:0] zero_offset;
      logic signed [COEF_W-1:0] zero_drift;
      logic signed [COEF_W-1:0] zero_drift_square;
      logic signed [COEF_W-1:0] slope_drift;
      logic signed [COEF_W-1:0] slope_drift_square;
      logic [RAW_W-1:0] temp_ref;
      logic [OUT_W-1:0] breakpoint;
      logic signed [COEF_W-1:0] first_region_gain;
      logic signed [COEF_W-1:0] first_region_square_coef;
      logic signed [COEF_W-1:0] second_region_gain;
      logic signed [COEF_W-1:0] second_region_square_coef;
      logic signed [COEF_W-1:0] temperature_gain;
      logic signed [COEF_W-1:0] temperature_offset;
      logic signed [COEF_W-1:0] temperature_square_coef;
   } coef_t;

   typedef struct packed {
      logic [OUT_W-1:0] cap;
      logic signed [OUT_W-1:0] temp;
   } result_t;
endpackage

// ---- src/stream_buffer.sv ----
// stream_buffer: small valid/ready buffer on the result path.
// assumes one clock and a synchronous reset; DEPTH is a power of two.
`timescale 1ns/1ps
module stream_buffer #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
) (
   // clock and reset
   input logic sys_clk_i,
   input logic reset_i,
   // fill side
   input logic in_valid_i,
   output logic in_ready_o,
   input logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("stream_buffer depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [WIDTH-1:0] nxt_mem [DEPTH];
   logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [PW:0] cnt_ff, nxt_cnt;
   logic push, pop;

   assign in_ready_o = cnt_ff != (PW+1)'(DEPTH);
   assign out_valid_o = cnt_ff != '0;
   assign out_data_o = mem_ff[rd_ff];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      nxt_mem = mem_ff;
      if (push) begin
         nxt_mem[wr_ff] = in_data_i;
      end
      nxt_wr = push ? PW'(wr_ff + 1'b1) : wr_ff;
      nxt_rd = pop ? PW'(rd_ff + 1'b1) : rd_ff;
      nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
   end

   // storage is data only and needs no reset
   always_ff @(posedge sys_clk_i) begin
      mem_ff <= nxt_mem;
      if (reset_i) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   AST_BUF_NO_OVERRUN: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      cnt_ff <= (PW+1)'(DEPTH)) else $error("buffer count beyond depth");
   AST_BUF_HOLD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
      else $error("stalled word changed or vanished");
   COV_BUF_FULL: cover property (@(posedge sys_clk_i) disable iff (reset_i) !in_ready_o);
endmodule

// ---- src/sensor_correction_math.sv ----
// sensor_correction_math: drift compensation, linearisation and
// temperature correction of one raw sample pair per request.
// assumes coefficients, mode and resolution come from same-clock logic and
// stay steady while a sample is in flight.
`timescale 1ns/1ps
module sensor_correction_math #(
   parameter int BUF_DEPTH = 2
) (
   // clock and reset
   input logic sys_clk_i,
   input logic reset_i,
   // raw samples from the converter front end
   input logic sample_valid_i,
   output logic sample_ready_o,
   input scm_pkg::sample_t sample_i,
   // calibration and configuration
   input scm_pkg::coef_t coef_i,
   input scm_pkg::mode_t mode_i,
   input logic [1:0] cap_res_i,
   input logic [1:0] temp_res_i,
   // corrected results
   output logic result_valid_o,
   input logic result_ready_i,
   output scm_pkg::result_t result_o
);
   if (BUF_DEPTH < 2) begin : g_chk
      $error("result buffer needs at least two entries");
   end

   typedef enum logic [2:0] {S_IDLE, S_DRIFT, S_DIV, S_POLY, S_PUSH} state_t;

   state_t state_ff, nxt_state;
   logic [13:0] cap_ff, nxt_cap, temp_ff, nxt_temp;
   scm_pkg::mode_t mode_ff, nxt_mode;
   logic neg_ff, nxt_neg;
   logic [31:0] den_ff, nxt_den;
   logic [32:0] rem_ff, nxt_rem;
   logic [47:0] dvd_ff, nxt_dvd, quo_ff, nxt_quo, mag_ff, nxt_mag;
   logic [5:0] cnt_ff, nxt_cnt;
   scm_pkg::result_t res_ff, nxt_res;

   logic signed [14:0] dt;
   logic signed [39:0] o_in, o_t, g_in, g_t, den_w;
   logic signed [31:0] num, num_abs;
   logic [32:0] rem_try;
   logic signed [49:0] corr;
   logic [15:0] x, x1, x2, cap_sat;
   logic signed [15:0] cubic_coef, temp_sat;
   logic signed [79:0] y1, y2, t_sq1, t_sq2, t_cub, poly;
   logic signed [47:0] rt, temp_w;
   logic buf_ready;

   // left-align a sample of the chosen resolution to 14 bits
   function automatic logic [13:0] align(input logic [13:0] r, input logic [1:0] res);
      logic [13:0] a;
      a = r;
      unique case (res)
         2'h0: a = {r[7:0], 6'h00};
         2'h1: a = {r[9:0], 4'h0};
         2'h2: a = {r[11:0], 2'h0};
         2'h3: a = r;
      endcase
      return a;
   endfunction

   // cubic term shares the storage slot of the second square coefficient
   assign cubic_coef = coef_i.second_region_square_coef;

   always_comb begin
      dt = $signed({1'b0, temp_ff}) - $signed({1'b0, coef_i.temp_ref});
      o_in = (40'(dt) * 40'($signed(coef_i.zero_drift_square))) >>> scm_pkg::DRIFT_SQ_SH;
      o_t = (40'(dt) * (40'($signed(coef_i.zero_drift)) + o_in)) >>> scm_pkg::DRIFT_SH;
      g_in = (40'(dt) * 40'($signed(coef_i.slope_drift_square))) >>> scm_pkg::DRIFT_SQ_SH;
      g_t = (40'(dt) * (40'($signed(coef_i.slope_drift)) + g_in)) >>> scm_pkg::DRIFT_SH;
      // offset pivots about midscale so gain drift does not move it
      num = 32'($signed({1'b0, cap_ff})) - 32'(scm_pkg::MID_SCALE)
            + 32'($signed(coef_i.zero_offset)) + 32'(o_t);
      num_abs = num < 0 ? -num : num;
      den_w = (40'sd1 <<< scm_pkg::DEN_SH) + g_t;
      rem_try = {rem_ff[31:0], dvd_ff[47]};
      corr = (neg_ff ? -50'($signed({1'b0, quo_ff})) : 50'($signed({1'b0, quo_ff})))
             + 50'(scm_pkg::MID_SCALE);
      if (corr < 0) begin
         x = 16'h0000;
      end else if (corr > 50'(scm_pkg::CAP_MAX)) begin
         x = 16'hffff;
      end else begin
         x = corr[15:0];
      end
      if (mode_ff == scm_pkg::MODE_THIRD_ORDER) begin
         x1 = x;
         x2 = 16'h0000;
      end else begin
         x1 = (x < coef_i.breakpoint) ? x : coef_i.breakpoint;
         x2 = (x > coef_i.breakpoint) ? x - coef_i.breakpoint : 16'h0000;
      end
      y1 = (80'($signed({1'b0, x1})) * 80'($signed(coef_i.first_region_gain))) >>> scm_pkg::GAIN_SH;
      y2 = (80'($signed({1'b0, x2})) * 80'($signed(coef_i.second_region_gain))) >>> scm_pkg::GAIN_SH;
      t_sq1 = (y1 * y1 * 80'($signed(coef_i.first_region_square_coef))) >>> scm_pkg::SQ_SH;
      t_sq2 = (y2 * y2 * 80'($signed(coef_i.second_region_square_coef))) >>> scm_pkg::SQ_SH;
      t_cub = (y1 * y1 * y1 * 80'(cubic_coef)) >>> scm_pkg::CUBE_SH;
      if (mode_ff == scm_pkg::MODE_THIRD_ORDER) begin
         poly = t_cub + t_sq1 + y1;
      end else begin
         poly = t_sq1 + y1 + t_sq2 + y2;
      end
      if (poly < 0) begin
         cap_sat = 16'h0000;
      end else if (poly > 80'(scm_pkg::CAP_MAX)) begin
         cap_sat = 16'hffff;
      end else begin
         cap_sat = poly[15:0];
      end
      rt = 48'($signed({1'b0, temp_ff}));
      temp_w = ((rt * rt * 48'($signed(coef_i.temperature_square_coef))) >>> scm_pkg::TSQ_SH)
               + ((rt * 48'($signed(coef_i.temperature_gain))) >>> scm_pkg::TG_SH)
               + 48'($signed(coef_i.temperature_offset));
      if (temp_w > 48'(scm_pkg::TEMP_MAX)) begin
         temp_sat = 16'sh7fff;
      end else if (temp_w < 48'(scm_pkg::TEMP_MIN)) begin
         temp_sat = -16'sh8000;
      end else begin
         temp_sat = temp_w[15:0];
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_cap = cap_ff;
      nxt_temp = temp_ff;
      nxt_mode = mode_ff;
      nxt_neg = neg_ff;
      nxt_den = den_ff;
      nxt_rem = rem_ff;
      nxt_dvd = dvd_ff;
      nxt_quo = quo_ff;
      nxt_mag = mag_ff;
      nxt_cnt = cnt_ff;
      nxt_res = res_ff;
      unique case (state_ff)
         S_IDLE: begin
            if (sample_valid_i) begin
               nxt_cap = align(sample_i.cap, cap_res_i);
               nxt_temp = align(sample_i.temp, temp_res_i);
               nxt_mode = mode_i;
               nxt_state = S_DRIFT;
            end
         end
         S_DRIFT: begin
            nxt_neg = num < 0;
            nxt_dvd = 48'(num_abs) << scm_pkg::DEN_SH;
            nxt_mag = 48'(num_abs) << scm_pkg::DEN_SH;
            // a denominator at or below zero is out of range: clamp rather than divide by it
            nxt_den = (den_w < 40'sd1) ? 32'h0000_0001 : den_w[31:0];
            nxt_rem = '0;
            nxt_quo = '0;
            nxt_cnt = scm_pkg::DIV_LAST;
            nxt_state = S_DIV;
         end
         S_DIV: begin
            // restoring division, one quotient bit a cycle, small area at a slow rate
            if (rem_try >= {1'b0, den_ff}) begin
               nxt_rem = rem_try - {1'b0, den_ff};
               nxt_quo = {quo_ff[46:0], 1'b1};
            end else begin
               nxt_rem = rem_try;
               nxt_quo = {quo_ff[46:0], 1'b0};
            end
            nxt_dvd = {dvd_ff[46:0], 1'b0};
            if (cnt_ff == 6'h00) begin
               nxt_state = S_POLY;
            end else begin
               nxt_cnt = cnt_ff - 6'h01;
            end
         end
         S_POLY: begin
            nxt_res.cap = cap_sat;
            nxt_res.temp = temp_sat;
            nxt_state = S_PUSH;
         end
         S_PUSH: begin
            if (buf_ready) begin
               nxt_state = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_ff <= S_IDLE;
         cap_ff <= '0;
         temp_ff <= '0;
         mode_ff <= scm_pkg::MODE_TWO_REGION;
         neg_ff <= 1'b0;
         den_ff <= 32'h0000_0001;
         rem_ff <= '0;
         dvd_ff <= '0;
         quo_ff <= '0;
         mag_ff <= '0;
         cnt_ff <= '0;
         res_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cap_ff <= nxt_cap;
         temp_ff <= nxt_temp;
         mode_ff <= nxt_mode;
         neg_ff <= nxt_neg;
         den_ff <= nxt_den;
         rem_ff <= nxt_rem;
         dvd_ff <= nxt_dvd;
         quo_ff <= nxt_quo;
         mag_ff <= nxt_mag;
         cnt_ff <= nxt_cnt;
         res_ff <= nxt_res;
      end
   end

   assign sample_ready_o = state_ff == S_IDLE;

   // a stalled receiver holds words in the buffer, and the datapath in S_PUSH once BUF_DEPTH words wait there
   stream_buffer #(
      .WIDTH($bits(scm_pkg::result_t)),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .in_valid_i(state_ff == S_PUSH),
      .in_ready_o(buf_ready),
      .in_data_i(res_ff),
      .out_valid_o(result_valid_o),
      .out_ready_i(result_ready_i),
      .out_data_o(result_o)
   );

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   AST_MODE_LATCH: assert property (
      state_ff == S_IDLE && sample_valid_i |=> state_ff == S_DRIFT && mode_ff == $past(mode_i))
      else $error("mode not taken with the sample");
   AST_DIV_EXACT: assert property (
      state_ff == S_POLY |-> rem_ff < {1'b0, den_ff}
      && 81'(quo_ff) * 81'(den_ff) + 81'(rem_ff) == 81'(mag_ff))
      else $error("quotient and remainder do not rebuild the dividend");
   AST_REGION_SPLIT: assert property (
      state_ff == S_POLY && mode_ff == scm_pkg::MODE_TWO_REGION
      |-> 17'(x1) + 17'(x2) == 17'(x) && x1 <= coef_i.breakpoint)
      else $error("region inputs do not split the value at the breakpoint");
   AST_REGION2_SILENT: assert property (
      state_ff == S_POLY && mode_ff == scm_pkg::MODE_TWO_REGION && x <= coef_i.breakpoint
      |-> poly == t_sq1 + y1)
      else $error("second region contributes below the breakpoint");
   AST_CUBIC_INPUT: assert property (
      state_ff == S_POLY && mode_ff == scm_pkg::MODE_THIRD_ORDER |-> x1 == x && poly == t_cub + t_sq1 + y1)
      else $error("third-order path does not use the whole value");
   AST_REGION2_IGNORED: assert property (
      state_ff == S_POLY && mode_ff == scm_pkg::MODE_THIRD_ORDER |-> y2 == 0)
      else $error("second gain reaches a single-region result");
   AST_NO_DRIFT_AT_REF: assert property (
      state_ff == S_DRIFT && temp_ff == coef_i.temp_ref |-> o_t == 0 && den_w == (40'sd1 <<< scm_pkg::DEN_SH))
      else $error("drift applied at the reference temperature");
   AST_OFFSET_MIDSCALE: assert property (
      state_ff == S_DRIFT && temp_ff == coef_i.temp_ref && coef_i.zero_offset == 0 && cap_ff == 14'h2000
      |=> mag_ff == '0)
      else $error("offset pivot is not at midscale");
   AST_TEMP_AT_ZERO: assert property (
      state_ff == S_POLY && temp_ff == 14'h0000 |=> res_ff.temp == coef_i.temperature_offset)
      else $error("temperature at zero reading differs from its offset");
   AST_TEMP_SAT: assert property (
      state_ff == S_POLY && temp_w > 48'(scm_pkg::TEMP_MAX) |=> res_ff.temp == 16'sh7fff)
      else $error("temperature did not saturate high");
   AST_RES_ALIGN: assert property (
      state_ff == S_IDLE && sample_valid_i && temp_res_i == 2'h0 |=> temp_ff[5:0] == 6'h00)
      else $error("8-bit temperature not left-aligned");
   AST_DIV_END: assert property (
      state_ff == S_DIV && cnt_ff == 6'h00 |=> state_ff == S_POLY ##1 state_ff == S_PUSH)
      else $error("division did not end on its last bit");
   AST_CAP_SAT: assert property (
      state_ff == S_POLY && poly < 0 |=> res_ff.cap == 16'h0000)
      else $error("negative capacitance result not clamped");

   COV_THIRD: cover property (state_ff == S_POLY && mode_ff == scm_pkg::MODE_THIRD_ORDER);
   COV_REGION2: cover property (state_ff == S_POLY && mode_ff == scm_pkg::MODE_TWO_REGION && x2 != 0);
   COV_STALL: cover property (state_ff == S_PUSH && !buf_ready);
   COV_TEMP_SAT: cover property (state_ff == S_POLY && temp_w > 48'(scm_pkg::TEMP_MAX));
endmodule

// ---- testbench/frontend_model.sv ----
// frontend_model: raw sample source standing in for the converter front end.
// assumes the block's ready output and one clock; drives on falling edges.
`timescale 1ns/1ps
module frontend_model (
   // clock
   input wire logic sys_clk_i,
   // handshake towards the block
   input wire logic ready_i,
   output logic valid_o,
   output scm_pkg::sample_t sample_o
);
   scm_pkg::sample_t held_ff = '0;
   logic idle_ff = 1'b0;
   initial valid_o = 1'b0;
   // a released bus changes every cycle so stale data is never taken for a sample
   always @(negedge sys_clk_i) idle_ff <= ~idle_ff;
   assign sample_o = valid_o ? held_ff : (idle_ff ? ~held_ff : held_ff ^ 28'h5555555);

   // offer one pair and hold it until the edge that takes it
   task automatic send(input scm_pkg::sample_t s);
      int n;
      n = 0;
      @(negedge sys_clk_i);
      held_ff = s;
      valid_o = 1'b1;
      while (ready_i !== 1'b1 && n < 200) begin
         @(negedge sys_clk_i);
         n++;
      end
      @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      valid_o = 1'b0;
   endtask
endmodule

// ---- testbench/sensor_correction_math_bench.sv ----
// sensor_correction_math_bench: self-checking bench with a scoreboard queue.
// assumes frontend_model as sample source; expected words come from a local model.
`timescale 1ns/1ps
module sensor_correction_math_bench;
   logic sys_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic result_ready_i = 1'b0;
   logic rnd_ready = 1'b0;
   logic sample_valid_i, sample_ready_o, result_valid_o;
   logic [1:0] cap_res_i = 2'h3;
   logic [1:0] temp_res_i = 2'h3;
   scm_pkg::sample_t sample_i;
   scm_pkg::coef_t coef_i = '0;
   scm_pkg::coef_t c;
   scm_pkg::mode_t mode_i = scm_pkg::MODE_TWO_REGION;
   scm_pkg::result_t result_o;
   scm_pkg::result_t expq[$];
   int n_fail = 0;
   int samples_checked = 0;
   int seed = 32'h234a;
   int n;

   initial forever #20 sys_clk_i = ~sys_clk_i;

   frontend_model frontend_model_i (.sys_clk_i(sys_clk_i), .ready_i(sample_ready_o),
      .valid_o(sample_valid_i), .sample_o(sample_i));
   sensor_correction_math sensor_correction_math_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .sample_i(sample_i),
      .coef_i(coef_i), .mode_i(mode_i), .cap_res_i(cap_res_i), .temp_res_i(temp_res_i),
      .result_valid_o(result_valid_o), .result_ready_i(result_ready_i), .result_o(result_o));

   function automatic longint clamp(longint v, longint lo, longint hi);
      return v < lo ? lo : (v > hi ? hi : v);
   endfunction

   // 64-bit arithmetic; coefficient limits below keep every product inside it
   function automatic scm_pkg::result_t ref_result(scm_pkg::coef_t k, scm_pkg::sample_t s, logic m,
      logic [1:0] cr, logic [1:0] tr);
      longint cap, rt, dt, off, gn, den, num, q, x, x1, x2, y1, y2, acc;
      scm_pkg::result_t r;
      cap = s.cap;
      cap = cap << (6 - 2 * cr);
      rt = s.temp;
      rt = rt << (6 - 2 * tr);
      dt = rt - longint'(k.temp_ref);
      off = (dt * (k.zero_drift + ((dt * k.zero_drift_square) >>> 8))) >>> 12;
      gn = (dt * (k.slope_drift + ((dt * k.slope_drift_square) >>> 8))) >>> 12;
      den = clamp(65536 + gn, 1, 64'h7fff_ffff);
      num = cap - 8192 + k.zero_offset + off;
      q = (num < 0 ? -num : num) * 65536 / den;
      x = clamp((num < 0 ? -q : q) + 8192, 0, 65535);
      x1 = (m == 1'b1 || x < k.breakpoint) ? x : longint'(k.breakpoint);
      x2 = (m == 1'b0 && x > k.breakpoint) ? x - k.breakpoint : 0;
      y1 = (x1 * k.first_region_gain) >>> 12;
      acc = y1 + ((y1 * y1 * k.first_region_square_coef) >>> 30);
      y2 = (x2 * k.second_region_gain) >>> 12;
      if (m == 1'b0) acc += y2 + ((y2 * y2 * k.second_region_square_coef) >>> 30);
      else acc += (y1 * y1 * y1 * k.second_region_square_coef) >>> 46;
      r.cap = 16'(clamp(acc, 0, 65535));
      acc = ((rt * rt * k.temperature_square_coef) >>> 28) + ((rt * k.temperature_gain) >>> 14);
      r.temp = 16'(clamp(acc + k.temperature_offset, -32768, 32767));
      return r;
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // waits for an idle block, applies settings, notes the expected word, offers the pair
   task automatic run(input logic m, input logic [1:0] cr, input logic [1:0] tr, input logic [27:0] raw);
      scm_pkg::sample_t s;
      int k;
      k = 0;
      s = raw;
      s.cap = s.cap >> (6 - 2 * cr);
      s.temp = s.temp >> (6 - 2 * tr);
      @(negedge sys_clk_i);
      while (sample_ready_o !== 1'b1 && k < 200) begin
         @(negedge sys_clk_i);
         k++;
      end
      coef_i = c;
      mode_i = scm_pkg::mode_t'(m);
      cap_res_i = cr;
      temp_res_i = tr;
      expq.push_back(ref_result(c, s, m, cr, tr));
      frontend_model_i.send(s);
   endtask

   task automatic rnd_coef();
      c = 222'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
         $random(seed)});
      c.zero_drift = 16'($random(seed) % 32'sh200);
      c.zero_drift_square = 16'($random(seed) % 32'sh10);
      c.slope_drift = 16'($random(seed) % 32'sh200);
      c.slope_drift_square = 16'($random(seed) % 32'sh10);
      // gain kept small so the cubic term stays inside 64-bit reference arithmetic
      c.first_region_gain = 16'($random(seed) % 32'sh800);
   endtask

   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // scoreboard: a word standing with ready high after the falling edge is popped at the next rising edge;
   // looking after the falling edge keeps clear of the edge that updates the buffer
   always @(negedge sys_clk_i) begin
      #1;
      if (!reset_i && result_valid_o === 1'b1 && result_ready_i === 1'b1) begin
         cmp(result_o, expq.size() > 0 ? expq.pop_front() : 'x);
      end
   end

   always @(negedge sys_clk_i) if (rnd_ready) result_ready_i <= 1'($random(seed));

   initial begin
      repeat (32'h7530) @(posedge sys_clk_i);
      n_fail++;
      conclude();
   end

   initial begin
      repeat (6) @(negedge sys_clk_i);
      reset_i = 1'b0;
      @(negedge sys_clk_i);
      cmp(32'(sample_ready_o), 32'h1);
      cmp(32'(result_valid_o), 32'h0);
      result_ready_i = 1'b1;
      // unit gains, doubled second region, breakpoint straddled at 1000
      c = '0;
      c.first_region_gain = 16'h1000;
      c.second_region_gain = 16'h2000;
      c.breakpoint = 16'h03e8;
      c.temperature_gain = 16'h4000;
      for (int i = 0; i < 4; i++) begin
         run(i == 3, 2'h3, 2'h3, {14'h03e7 + 14'(i), 14'h1000});
         if (i == 0) begin
            cmp(32'(sample_ready_o), 32'h0);
            n = 0;
            do begin
               @(posedge sys_clk_i);
               #1;
               n++;
            end while (result_valid_o !== 1'b1 && n < 100);
            // drift, 48 quotient bits, polynomial and push: the word shows 51 edges after the taking edge
            cmp(32'(n), 32'h33);
         end
      end
      // midscale capacitance at the reference temperature with a raw temperature of zero
      run(1'b0, 2'h3, 2'h3, {14'h2000, 14'h0000});
      // every resolution code on both channels
      for (int r = 0; r < 4; r++) begin
         rnd_coef();
         run(1'($random(seed)), 2'(r), 2'(3 - r), 28'($random(seed)));
      end
      // let the last word drain, or it would take one of the two buffer slots below
      repeat (60) @(negedge sys_clk_i);
      // receiver stalled: two words buffered, third held back, none lost
      result_ready_i = 1'b0;
      for (int i = 0; i < 3; i++) begin
         rnd_coef();
         run(1'($random(seed)), 2'h3, 2'h3, 28'($random(seed)));
      end
      repeat (60) @(negedge sys_clk_i);
      cmp(32'(sample_ready_o), 32'h0);
      cmp(32'(result_valid_o), 32'h1);
      result_ready_i = 1'b1;
      // random traffic with a stalling receiver; the random driver starts an edge later so ready has one writer
      @(negedge sys_clk_i);
      rnd_ready = 1'b1;
      for (int i = 0; i < 40; i++) begin
         rnd_coef();
         run(1'($random(seed)), 2'($random(seed)), 2'($random(seed)), 28'($random(seed)));
      end
      @(negedge sys_clk_i);
      rnd_ready = 1'b0;
      @(negedge sys_clk_i);
      result_ready_i = 1'b1;
      n = 0;
      while (expq.size() > 0 && n < 300) begin
         @(negedge sys_clk_i);
         n++;
      end
      cmp(32'(expq.size()), 32'h0);
      conclude();
   end
endmodule
